// file: core/wdog_pkg.sv
// Package: constants and carrier types for the windowed watchdog supervisor
// Assumes a 25 MHz core clock as the oscillator time base
package wdog_pkg;
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned WD_PERIOD_MS    = 100;
  localparam int unsigned SENSE_US        = 5;
  localparam int unsigned KICK_TARGET     = 3;
  // Derived tick counts, all from the one time base
  localparam int unsigned WD_PERIOD_CYC   = WD_PERIOD_MS * (CLK_HZ / 1000);
  localparam int unsigned CLOSED_CYC      = (WD_PERIOD_CYC / 10) * 8;
  localparam int unsigned OPEN_CYC        = (WD_PERIOD_CYC / 10) * 4;
  localparam int unsigned PULSE_CYC       = WD_PERIOD_CYC / 40;
  localparam int unsigned SENSE_CYC       = SENSE_US * (CLK_HZ / 1_000_000);

  typedef enum logic [3:0] {
    ST_DOWN   = 4'b0001,
    ST_POR    = 4'b0010,
    ST_RUN    = 4'b0100,
    ST_PULSE  = 4'b1000
  } wd_state_t;

  typedef struct packed {
    logic sys_rst_n;
    logic sys_rst_oe;
    logic sys_permit_n;
  } sup_out_t;
endpackage

// file: core/wdog_timer.sv
// Tick counter with terminal flag; shared time base for the power-on, window and pulse intervals
// Assumes caller loads a limit and restarts on state change
`timescale 1ns/10ps
`default_nettype none
module wdog_timer #(
  parameter int unsigned WIDTH = 32
) (
  input  wire logic             core_clk_i,
  input  wire logic             reset_i,
  input  wire logic             restart_i,
  input  wire logic [WIDTH-1:0] limit_i,
  output logic [WIDTH-1:0]      count_o,
  output logic                  done_o
);
  initial begin
    if (WIDTH < 2) $error("wdog_timer width too small");
  end

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } tmr_state_t;

  tmr_state_t s_q;
  tmr_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (restart_i) begin
      s_d.cnt = '0;
    end else if (s_q.cnt != limit_i) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign count_o = s_q.cnt;
  // Flag from the count compared with limit_i: the caller derives restart from it
  assign done_o  = (s_q.cnt == limit_i);
endmodule
`default_nettype wire

// file: core/wdog_supervisor.sv
// Windowed watchdog supervisor: power-on/down reset, window watchdog, enable
// Assumes vin_above_i is a raw comparator level and wd_kick_in a pin
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// (RQ1) Hold reset one period after voltage returns
// (RQ2) Voltage below threshold drives reset low
// (RQ3) All intervals from one tick base
// (RQ4) Watchdog reset pulse is period over 40
// (RQ5) Closed window lasts 0.8 period after restart
// (RQ6) Open window follows, lasting 0.4 period
// (RQ7) Processor kicks inside open window, with margin
// (RQ8) Kick in open window restarts timer quietly
// (RQ9) Kick in closed window causes reset
// (RQ10) No kick by window end pulses reset
// (RQ11) Missing kicks repeat reset as square wave
// (RQ12) Ignore kicks until power-on delay ends
// (RQ13) Sustained drop overrides watchdog, disables enable
// (RQ14) Enable active after three good kicks
// (RQ15) Reset open drain, enable push pull
// (RQ16) Sync kick, falling edge is one service
module wdog_supervisor #(
  parameter int unsigned WD_PERIOD_CYC = wdog_pkg::WD_PERIOD_CYC,
  parameter int unsigned SENSE_CYC     = wdog_pkg::SENSE_CYC,
  parameter int unsigned KICK_TARGET   = wdog_pkg::KICK_TARGET
) (
  input  wire logic core_clk_i,
  input  wire logic reset_i,
  input  wire logic vin_above_i,
  input  wire logic wd_kick_in,
  output logic      sys_rst_n_o,
  output logic      sys_rst_oe_o,
  output logic      sys_permit_n_o
);
  localparam int unsigned CLOSED = (WD_PERIOD_CYC / 10) * 8;
  localparam int unsigned OPEN   = (WD_PERIOD_CYC / 10) * 4;
  localparam int unsigned PULSE  = WD_PERIOD_CYC / 40;
  localparam int unsigned TW     = 32;
  localparam int unsigned SW     = 16;

  initial begin
    if (WD_PERIOD_CYC < 40 || WD_PERIOD_CYC % 40 != 0) $error("period must be multiple of 40");
    if (SENSE_CYC < 1 || SENSE_CYC > 65535) $error("bad sense count");
    if (KICK_TARGET < 1 || KICK_TARGET > 7) $error("bad kick target");
  end

  typedef struct packed {
    logic [1:0]          vin_sync;
    logic [2:0]          kick_sync;
    logic [SW-1:0]       low_cnt;
    logic                vin_ok;
    wdog_pkg::wd_state_t state;
    logic [2:0]          good;
    wdog_pkg::sup_out_t  outp;
  } sup_state_t;

  sup_state_t s_q;
  sup_state_t s_d;

  ////////////////////////////////////////////////////////////////////////////////
  // Shared timer
  logic          tmr_restart;
  logic [TW-1:0] tmr_limit;
  logic [TW-1:0] tmr_count;
  logic          tmr_done;

  wdog_timer #(.WIDTH(TW)) u_timer (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .restart_i  (tmr_restart),
    .limit_i    (tmr_limit),
    .count_o    (tmr_count),
    .done_o     (tmr_done)
  );

  function automatic logic [TW-1:0] to_tw(input int unsigned v);
    to_tw = TW'(v);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Next state
  logic kick_fall;
  logic in_open;
  logic vin_drop;

  always_comb begin
    s_d         = s_q;
    tmr_restart = 1'b0;
    tmr_limit   = to_tw(WD_PERIOD_CYC);
    s_d.vin_sync  = {s_q.vin_sync[0], vin_above_i};
    s_d.kick_sync = {s_q.kick_sync[1:0], wd_kick_in};
    kick_fall = s_q.kick_sync[2] && !s_q.kick_sync[1]; // RQ16
    in_open   = tmr_count >= to_tw(CLOSED);
    vin_drop  = 1'b0;
    // Low must persist for the sensing time before it counts
    if (s_q.vin_sync[1]) begin
      s_d.low_cnt = '0;
      s_d.vin_ok  = 1'b1;
    end else if (s_q.low_cnt != SW'(SENSE_CYC - 1)) begin
      s_d.low_cnt = s_q.low_cnt + 1'b1;
    end else begin
      s_d.vin_ok = 1'b0;
      vin_drop   = 1'b1; // RQ2
    end
    case (s_q.state)
      wdog_pkg::ST_DOWN: begin
        tmr_restart = 1'b1;
        if (s_q.vin_ok) begin
          s_d.state = wdog_pkg::ST_POR; // RQ1
        end
      end
      wdog_pkg::ST_POR: begin
        tmr_limit = to_tw(WD_PERIOD_CYC); // RQ1 RQ3
        if (tmr_done) begin
          tmr_restart = 1'b1; // RQ12
          s_d.state   = wdog_pkg::ST_RUN;
        end
      end
      wdog_pkg::ST_RUN: begin
        tmr_limit = to_tw(CLOSED + OPEN); // RQ5 RQ6
        if (kick_fall && in_open) begin
          tmr_restart = 1'b1; // RQ8
          if (s_q.good != 3'(KICK_TARGET)) begin
            s_d.good = s_q.good + 1'b1; // RQ14
          end
        end else if (kick_fall || tmr_done) begin
          tmr_restart = 1'b1; // RQ9 RQ10 RQ11
          s_d.good    = '0;
          s_d.state   = wdog_pkg::ST_PULSE;
        end
      end
      wdog_pkg::ST_PULSE: begin
        tmr_limit = to_tw(PULSE); // RQ4
        if (tmr_done) begin
          tmr_restart = 1'b1;
          s_d.state   = wdog_pkg::ST_RUN;
        end
      end
      default: begin
        s_d.state = wdog_pkg::ST_DOWN;
      end
    endcase
    if (vin_drop || !s_q.vin_ok) begin
      s_d.state   = wdog_pkg::ST_DOWN; // RQ13
      s_d.good    = '0;
      tmr_restart = 1'b1;
    end
    s_d.outp.sys_rst_n    = (s_d.state == wdog_pkg::ST_RUN);
    s_d.outp.sys_rst_oe   = !s_d.outp.sys_rst_n; // RQ15
    s_d.outp.sys_permit_n = !(s_d.outp.sys_rst_n && s_d.good == 3'(KICK_TARGET)); // RQ14
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_q.vin_sync  <= '0;
      s_q.kick_sync <= 3'h7;
      s_q.low_cnt   <= '0;
      s_q.vin_ok    <= 1'b0;
      s_q.state     <= wdog_pkg::ST_DOWN;
      s_q.good      <= '0;
      s_q.outp      <= 3'h3;
    end else begin
      s_q <= s_d;
    end
  end

  assign sys_rst_n_o    = s_q.outp.sys_rst_n;
  assign sys_rst_oe_o   = s_q.outp.sys_rst_oe;
  assign sys_permit_n_o = s_q.outp.sys_permit_n;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  a_permit_off_in_reset: assert property (@(posedge core_clk_i) disable iff (reset_i) // RQ14
    !sys_rst_n_o |-> sys_permit_n_o) else $error("permit active during reset");
  a_oe_matches_low: assert property (@(posedge core_clk_i) disable iff (reset_i) // RQ15
    sys_rst_oe_o == !sys_rst_n_o) else $error("open drain enable wrong");
  a_early_kick_resets: assert property (@(posedge core_clk_i) disable iff (reset_i) // RQ9
    (s_q.state == wdog_pkg::ST_RUN && kick_fall && !in_open && s_q.vin_ok && s_q.vin_sync[1])
    |=> !sys_rst_n_o) else $error("early kick did not reset");
  a_open_kick_quiet: assert property (@(posedge core_clk_i) disable iff (reset_i) // RQ8
    (s_q.state == wdog_pkg::ST_RUN && kick_fall && in_open && s_q.vin_ok && s_q.vin_sync[1])
    |=> sys_rst_n_o && tmr_count == '0) else $error("open kick misbehaved");
  a_timeout_pulse: assert property (@(posedge core_clk_i) disable iff (reset_i) // RQ10
    (s_q.state == wdog_pkg::ST_RUN && tmr_done && !kick_fall && s_q.vin_ok && s_q.vin_sync[1])
    |=> !sys_rst_n_o) else $error("timeout gave no pulse");
  a_drop_forces_reset: assert property (@(posedge core_clk_i) disable iff (reset_i) // RQ13
    vin_drop |=> !sys_rst_n_o && sys_permit_n_o) else $error("drop did not force reset");
  a_pulse_length: assert property (@(posedge core_clk_i) disable iff (reset_i) // RQ4
    (s_q.state == wdog_pkg::ST_PULSE && tmr_count == to_tw(PULSE) && s_q.vin_ok && s_q.vin_sync[1])
    |=> sys_rst_n_o) else $error("pulse length wrong");
  a_por_release: assert property (@(posedge core_clk_i) disable iff (reset_i) // RQ1
    (s_q.state == wdog_pkg::ST_POR && tmr_count < to_tw(WD_PERIOD_CYC)) |-> !sys_rst_n_o)
    else $error("released before power-on delay");
endmodule
`default_nettype wire

// file: tb/cpu_model.sv
// Processor model: pulses the clear input low after a commanded gap
// Assumes the reset wire level is resolved outside, with pull-up
`timescale 1ns/10ps
`default_nettype none
module cpu_model (
  input  wire logic        core_clk_i,
  input  wire logic        rst_wire_i,
  input  wire logic        kick_en_i,
  input  wire logic [15:0] gap_i,
  output logic             kick_n_o
);
  logic [15:0] cnt_q;
  ////////////////////////////////////////////////////////////////////////////
  // Gap counted from own restart; clear pulse low for the last 4 cycles
  always_ff @(posedge core_clk_i) begin
    if (!rst_wire_i || !kick_en_i) begin
      cnt_q    <= 16'h0000;
      kick_n_o <= 1'b1;
    end else begin
      cnt_q    <= (cnt_q >= gap_i) ? 16'h0000 : cnt_q + 16'h0001;
      kick_n_o <= !(cnt_q + 16'h0004 > gap_i);
    end
  end
endmodule
`default_nettype wire

// file: tb/windowed_watchdog_supervisor_tb.sv
// Self-checking bench for the windowed watchdog supervisor
// Assumes a shortened period of 400 cycles and a 2-cycle voltage filter
`timescale 1ns/10ps
`default_nettype none
module windowed_watchdog_supervisor_tb;
  localparam int P = 400;
  logic        core_clk_i = 1'b0;
  logic        reset_i    = 1'b1;
  logic        vin_above_i = 1'b0;
  logic        kick_en    = 1'b0;
  logic [15:0] gap        = 16'h0186;
  logic        wd_kick_in;
  logic        sys_rst_n_o;
  logic        sys_rst_oe_o;
  logic        sys_permit_n_o;
  logic        rst_wire;
  logic        kick_prev;
  int          bad_count = 0;
  int          checked   = 0;
  int          n;
  int          lows;
  int          kicks;
  always #20 core_clk_i = ~core_clk_i;
  assign rst_wire = sys_rst_oe_o ? 1'b0 : 1'b1;
  wdog_supervisor #(.WD_PERIOD_CYC(P), .SENSE_CYC(2), .KICK_TARGET(3)) uut (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .vin_above_i(vin_above_i), .wd_kick_in(wd_kick_in),
    .sys_rst_n_o(sys_rst_n_o), .sys_rst_oe_o(sys_rst_oe_o), .sys_permit_n_o(sys_permit_n_o));
  cpu_model cpu (.core_clk_i(core_clk_i), .rst_wire_i(rst_wire), .kick_en_i(kick_en), .gap_i(gap),
    .kick_n_o(wd_kick_in));
  ////////////////////////////////////////////////////////////////////////////
  function automatic int run_len(int p);
    return (p / 10) * 8 + (p / 10) * 4 + 1;
  endfunction
  task automatic chk(string nm, int lo, int hi, int got);
    checked++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask
  task automatic chk_b(string nm, logic e, logic g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic wait_rst(logic lvl, output int c);
    c = 0;
    while (rst_wire !== lvl && c < 3000) begin
      @(negedge core_clk_i);
      c++;
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(40 * 20000);
    bad_count++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'h8812_ec9b));
    repeat (2) @(negedge core_clk_i);
    reset_i = 1'b0;
    chk_b("permit_n after reset", 1'b1, sys_permit_n_o);
    vin_above_i = 1'b1;
    wait_rst(1'b1, n);
    chk("power-on delay", P, P + 6, n);
    wait_rst(1'b0, n);
    chk("windows length", run_len(P) - 1, run_len(P) + 1, n);
    wait_rst(1'b1, n);
    chk("reset pulse width", P / 40 + 1, P / 40 + 1, n);
    wait_rst(1'b0, n);
    chk("square wave high", run_len(P) - 1, run_len(P) + 1, n);
    wait_rst(1'b1, n);
    $display("test timeout done");
    kick_en = 1'b1;
    lows = 0;
    kicks = 0;
    n = 0;
    kick_prev = 1'b1;
    while (kicks < 3 && n < 2000) begin
      @(negedge core_clk_i);
      n++;
      lows += (rst_wire !== 1'b1);
      if (kick_prev && !wd_kick_in) begin
        kicks++;
        chk_b("permit_n before third kick", 1'b1, sys_permit_n_o);
      end
      if (!kick_prev && wd_kick_in) gap = 16'(340 + $urandom_range(120));
      kick_prev = wd_kick_in;
    end
    chk("good kicks seen", 3, 3, kicks);
    repeat (6) @(negedge core_clk_i);
    chk("reset lows while kicked", 0, 0, lows);
    chk_b("permit_n after three kicks", 1'b0, sys_permit_n_o);
    @(posedge wd_kick_in);
    @(negedge core_clk_i);
    gap = 16'h00c8;
    $display("test good kicks done");
    wait_rst(1'b0, n);
    chk("early kick reset", 195, 212, n);
    chk_b("permit_n on early kick", 1'b1, sys_permit_n_o);
    kick_en = 1'b0;
    wait_rst(1'b1, n);
    chk("pulse after early kick", P / 40, P / 40 + 1, n);
    $display("test early kick done");
    vin_above_i = 1'b0;
    @(negedge core_clk_i);
    vin_above_i = 1'b1;
    lows = 0;
    repeat (8) begin
      @(negedge core_clk_i);
      lows += (rst_wire !== 1'b1);
    end
    chk("glitch ignored", 0, 0, lows);
    vin_above_i = 1'b0;
    wait_rst(1'b0, n);
    chk("power-down reset", 2, 8, n);
    chk_b("permit_n on drop", 1'b1, sys_permit_n_o);
    kick_en = 1'b1;
    lows = 0;
    repeat (600) begin
      @(negedge core_clk_i);
      lows += (rst_wire !== 1'b0);
    end
    chk("held down while low", 0, 0, lows);
    vin_above_i = 1'b1;
    wait_rst(1'b1, n);
    chk("second power-on delay", P, P + 6, n);
    chk_b("sys_rst_n_o released", 1'b1, sys_rst_n_o);
    $display("test voltage done");
    end_of_test();
  end
endmodule
`default_nettype wire
